// >>> verilog/two_stage_event_controller.sv
/*
 * two_stage_event_controller: system routing stage plus core event stage.
 * assumes: peripheral lines asynchronous; core pipeline on i_ref_clk.
 */
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module two_stage_event_controller #(
    parameter int NUM_SRC = event_ctrl_pkg::NUM_SRC
) (
    input  wire logic                i_ref_clk,
    input  wire logic                i_sys_rst,
    input  wire logic [NUM_SRC-1:0]  i_periph_irq,
    input  wire logic                i_supervisor,
    input  wire logic                i_global_irq_enable_instr,
    input  wire logic                i_global_irq_disable_instr,
    input  wire logic                i_core_idle,
    input  wire logic                i_evt_accept,
    input  wire logic [15:0]         i_evt_return,
    output logic                     o_evt_req,
    output logic [3:0]               o_evt_level,
    output logic [15:0]              o_core_event_nesting,
    output logic                     o_wake,
    input  wire logic [7:0]          i_s_axi_awaddr,
    input  wire logic                i_s_axi_awvalid,
    output logic                     o_s_axi_awready,
    input  wire logic [31:0]         i_s_axi_wdata,
    input  wire logic [3:0]          i_s_axi_wstrb,
    input  wire logic                i_s_axi_wvalid,
    output logic                     o_s_axi_wready,
    output logic [1:0]               o_s_axi_bresp,
    output logic                     o_s_axi_bvalid,
    input  wire logic                i_s_axi_bready,
    input  wire logic [7:0]          i_s_axi_araddr,
    input  wire logic                i_s_axi_arvalid,
    output logic                     o_s_axi_arready,
    output logic [31:0]              o_s_axi_rdata,
    output logic [1:0]               o_s_axi_rresp,
    output logic                     o_s_axi_rvalid,
    input  wire logic                i_s_axi_rready
);
    localparam int NE = event_ctrl_pkg::NUM_EVT;

    logic [NUM_SRC-1:0] sync1_ff;
    logic [NUM_SRC-1:0] line_ff;
    logic [63:0]        punmask_ff;
    logic [63:0]        pwake_ff;
    logic [31:0]        assign_ff [event_ctrl_pkg::NUM_ASSIGN];
    logic [NE-1:0]      lvl_in;
    logic [NE-1:0]      lvl_prev_ff;
    logic [NE-1:0]      latch_ff;
    logic [NE-1:0]      unmask_ff;
    logic [NE-1:0]      nesting_ff;
    logic               gie_ff;
    logic [NE-1:0]      rise;
    logic [NE-1:0]      grant;
    logic [NE-1:0]      eligible;
    logic [3:0]         sel_lvl;
    logic               sel_any;
    logic               wake_cond;
    logic [63:0]        line_w;
    // address/data holding for the write path
    logic               aw_ff;
    logic               w_ff;
    logic [7:0]         awaddr_ff;
    logic [31:0]        wdata_ff;
    logic [3:0]         wstrb_ff;
    logic               do_write;
    logic [1:0]         nxt_bresp;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit_assign(input logic [7:0] a);
        return a >= event_ctrl_pkg::OFS_ASSIGN0 &&
               a < event_ctrl_pkg::OFS_ASSIGN0 + 8'(4 * event_ctrl_pkg::NUM_ASSIGN);
    endfunction

    function automatic int assign_idx(input logic [7:0] a);
        return int'((a - event_ctrl_pkg::OFS_ASSIGN0) >> 2);
    endfunction

    // peripheral lines are asynchronous, two flops first
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            sync1_ff <= '0;
            line_ff  <= '0;
        end else begin
            sync1_ff <= i_periph_irq;
            line_ff  <= sync1_ff;
        end
    end

    always_comb begin
        line_w = '0;
        line_w[NUM_SRC-1:0] = line_ff;
    end

    // route unmasked sources onto general levels; several may share one level
    always_comb begin
        logic [3:0] fld;
        fld    = '0;
        lvl_in = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            fld = assign_ff[s / 8][(s % 8) * 4 +: 4];
            if (line_w[s] && punmask_ff[s] && !event_ctrl_pkg::RSVD_SRC[s]
                && fld <= 4'(event_ctrl_pkg::LAST_GP_LEVEL - event_ctrl_pkg::FIRST_GP_LEVEL)) begin
                lvl_in[4'(event_ctrl_pkg::FIRST_GP_LEVEL) + fld] = 1'b1;
            end
        end
    end

    // edge detect over the registered level: one cycle from synced line
    assign rise = lvl_in & ~lvl_prev_ff;
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            lvl_prev_ff <= '0;
        end else begin
            lvl_prev_ff <= lvl_in;
        end
    end

    // highest-priority eligible level, lowest number wins
    always_comb begin
        eligible = latch_ff & unmask_ff & {NE{gie_ff}};
        eligible[event_ctrl_pkg::FIRST_GP_LEVEL-1:0] = '0;
        sel_any = 1'b0;
        sel_lvl = '0;
        for (int l = event_ctrl_pkg::LAST_GP_LEVEL; l >= event_ctrl_pkg::FIRST_GP_LEVEL; l--) begin
            if (eligible[l] && !(|(nesting_ff & (16'hFFFF >> (NE - 1 - l))))) begin
                sel_any = 1'b1;
                sel_lvl = 4'(l);
            end
        end
    end

    assign o_evt_req   = sel_any;
    assign o_evt_level = sel_lvl;
    assign grant       = (sel_any && i_evt_accept) ? (16'h0001 << sel_lvl) : '0;

    // hardware set wins over software clear and over acceptance clear
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            latch_ff <= event_ctrl_pkg::LATCH_RST;
        end else begin
            for (int l = 0; l < NE; l++) begin
                if (rise[l]) begin
                    latch_ff[l] <= 1'b1;
                end else if (grant[l]) begin
                    latch_ff[l] <= 1'b0;
                end else if (do_write && awaddr_ff == event_ctrl_pkg::OFS_LATCH
                             && !unmask_ff[l] && wstrb_ff[l/8]) begin
                    latch_ff[l] <= wdata_ff[l];
                end
            end
        end
    end

    // nesting: set on entry to pipeline, cleared on return from the event
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            nesting_ff <= '0;
        end else begin
            nesting_ff <= (nesting_ff & ~i_evt_return) | grant;
        end
    end
    assign o_core_event_nesting = nesting_ff;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            gie_ff <= 1'b1;
        end else if (i_global_irq_disable_instr) begin
            gie_ff <= 1'b0;
        end else if (i_global_irq_enable_instr) begin
            gie_ff <= 1'b1;
        end
    end

    assign wake_cond = |(line_w & punmask_ff & pwake_ff);
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= wake_cond && i_core_idle;
        end
    end

    // write channel: address and data taken independently
    assign o_s_axi_awready = !aw_ff && !o_s_axi_bvalid;
    assign o_s_axi_wready  = !w_ff && !o_s_axi_bvalid;
    assign do_write        = aw_ff && w_ff;

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff  <= '0;
            wstrb_ff  <= '0;
        end else begin
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_ff     <= 1'b1;
                awaddr_ff <= i_s_axi_awaddr;
            end else if (do_write) begin
                aw_ff <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_ff     <= 1'b1;
                wdata_ff <= i_s_axi_wdata;
                wstrb_ff <= i_s_axi_wstrb;
            end else if (do_write) begin
                w_ff <= 1'b0;
            end
        end
    end

    always_comb begin
        nxt_bresp = event_ctrl_pkg::RESP_OKAY;
        unique case (awaddr_ff)
            event_ctrl_pkg::OFS_LATCH,
            event_ctrl_pkg::OFS_PUNMASK0, event_ctrl_pkg::OFS_PUNMASK1,
            event_ctrl_pkg::OFS_PWAKE0, event_ctrl_pkg::OFS_PWAKE1,
            event_ctrl_pkg::OFS_GLOBAL: nxt_bresp = event_ctrl_pkg::RESP_OKAY;
            event_ctrl_pkg::OFS_UNMASK:
                nxt_bresp = i_supervisor ? event_ctrl_pkg::RESP_OKAY
                                         : event_ctrl_pkg::RESP_SLVERR;
            default: nxt_bresp = hit_assign(awaddr_ff) ? event_ctrl_pkg::RESP_OKAY
                                                       : event_ctrl_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp  <= event_ctrl_pkg::RESP_OKAY;
        end else if (do_write) begin
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp  <= nxt_bresp;
        end else if (i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            unmask_ff <= event_ctrl_pkg::UNMASK_RST;
        end else if (do_write && awaddr_ff == event_ctrl_pkg::OFS_UNMASK && i_supervisor) begin
            unmask_ff <= 16'(merge(32'(unmask_ff), wdata_ff, wstrb_ff));
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            punmask_ff <= {event_ctrl_pkg::PMASK_RST, event_ctrl_pkg::PMASK_RST};
            pwake_ff   <= {event_ctrl_pkg::PWAKE_RST, event_ctrl_pkg::PWAKE_RST};
        end else if (do_write) begin
            unique case (awaddr_ff)
                event_ctrl_pkg::OFS_PUNMASK0:
                    punmask_ff[31:0] <= merge(punmask_ff[31:0], wdata_ff, wstrb_ff);
                event_ctrl_pkg::OFS_PUNMASK1:
                    punmask_ff[63:32] <= merge(punmask_ff[63:32], wdata_ff, wstrb_ff);
                event_ctrl_pkg::OFS_PWAKE0:
                    pwake_ff[31:0] <= merge(pwake_ff[31:0], wdata_ff, wstrb_ff);
                event_ctrl_pkg::OFS_PWAKE1:
                    pwake_ff[63:32] <= merge(pwake_ff[63:32], wdata_ff, wstrb_ff);
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < event_ctrl_pkg::NUM_ASSIGN; i++) begin
                assign_ff[i] <= event_ctrl_pkg::ASSIGN_RST[i];
            end
        end else if (do_write && hit_assign(awaddr_ff)) begin
            assign_ff[assign_idx(awaddr_ff)] <=
                merge(assign_ff[assign_idx(awaddr_ff)], wdata_ff, wstrb_ff);
        end
    end

    // read channel, answer one cycle after the address is taken
    assign o_s_axi_arready = !o_s_axi_rvalid;
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata  <= '0;
            o_s_axi_rresp  <= event_ctrl_pkg::RESP_OKAY;
        end else if (i_s_axi_arvalid && o_s_axi_arready) begin
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rresp  <= event_ctrl_pkg::RESP_OKAY;
            o_s_axi_rdata  <= '0;
            unique case (i_s_axi_araddr)
                event_ctrl_pkg::OFS_LATCH:    o_s_axi_rdata <= 32'(latch_ff);
                event_ctrl_pkg::OFS_UNMASK: begin
                    if (i_supervisor) begin
                        o_s_axi_rdata <= 32'(unmask_ff);
                    end else begin
                        o_s_axi_rresp <= event_ctrl_pkg::RESP_SLVERR;
                    end
                end
                event_ctrl_pkg::OFS_NESTING: begin
                    if (i_supervisor) begin
                        o_s_axi_rdata <= 32'(nesting_ff);
                    end else begin
                        o_s_axi_rresp <= event_ctrl_pkg::RESP_SLVERR;
                    end
                end
                event_ctrl_pkg::OFS_PUNMASK0: o_s_axi_rdata <= punmask_ff[31:0];
                event_ctrl_pkg::OFS_PUNMASK1: o_s_axi_rdata <= punmask_ff[63:32];
                event_ctrl_pkg::OFS_PSTATE0:  o_s_axi_rdata <= line_w[31:0];
                event_ctrl_pkg::OFS_PSTATE1:  o_s_axi_rdata <= line_w[63:32];
                event_ctrl_pkg::OFS_PWAKE0:   o_s_axi_rdata <= pwake_ff[31:0];
                event_ctrl_pkg::OFS_PWAKE1:   o_s_axi_rdata <= pwake_ff[63:32];
                event_ctrl_pkg::OFS_GLOBAL:   o_s_axi_rdata <= {31'h0000_0000, gie_ff};
                default: begin
                    if (hit_assign(i_s_axi_araddr)) begin
                        o_s_axi_rdata <= assign_ff[assign_idx(i_s_axi_araddr)];
                    end else begin
                        o_s_axi_rresp <= event_ctrl_pkg::RESP_SLVERR;
                    end
                end
            endcase
        end else if (i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// >>> verilog/event_ctrl_pkg.sv
/*
 * constants for the two-stage event controller: register offsets,
 * default routing, field layouts.
 * assumes a 32-bit axi4-lite register bus and one core clock.
 */
package event_ctrl_pkg;
    localparam int          NUM_SRC        = 56;
    localparam int          NUM_EVT        = 16;
    localparam int          NUM_ASSIGN     = 7;
    localparam int          FIELD_W        = 4;
    localparam int          FIRST_GP_LEVEL = 7;
    localparam int          LAST_GP_LEVEL  = 15;
    localparam logic [7:0]  OFS_LATCH      = 8'h00;
    localparam logic [7:0]  OFS_UNMASK     = 8'h04;
    localparam logic [7:0]  OFS_NESTING    = 8'h08;
    localparam logic [7:0]  OFS_PUNMASK0   = 8'h10;
    localparam logic [7:0]  OFS_PUNMASK1   = 8'h14;
    localparam logic [7:0]  OFS_PSTATE0    = 8'h18;
    localparam logic [7:0]  OFS_PSTATE1    = 8'h1C;
    localparam logic [7:0]  OFS_PWAKE0     = 8'h20;
    localparam logic [7:0]  OFS_PWAKE1     = 8'h24;
    localparam logic [7:0]  OFS_ASSIGN0    = 8'h30;
    localparam logic [7:0]  OFS_GLOBAL     = 8'h50;
    localparam logic [15:0] LATCH_RST      = 16'h0000;
    localparam logic [15:0] UNMASK_RST     = 16'h0000;
    localparam logic [31:0] PMASK_RST      = 32'h0000_0000;
    localparam logic [31:0] PWAKE_RST      = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    // reset routing, one nibble per source id, 8 per assignment word
    localparam logic [31:0] ASSIGN_RST [NUM_ASSIGN] = '{
        32'h0000_0000, 32'h2211_0000, 32'h3333_2222, 32'h0444_4433,
        32'h5555_5555, 32'h0666_6655, 32'h3333_3003
    };
    // reserved ids never reach the core stage
    localparam logic [63:0] RSVD_SRC       = 64'hFF06_0000_8000_0800;
endpackage

// >>> testbench/event_ctrl_chk.sv
/* checker for the event controller top ports.
   assumes one core clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module event_ctrl_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_global_irq_disable_instr,
    input wire logic        i_core_idle,
    input wire logic        i_evt_accept,
    input wire logic [15:0] i_evt_return,
    input wire logic        o_evt_req,
    input wire logic [3:0]  o_evt_level,
    input wire logic [15:0] o_core_event_nesting,
    input wire logic        o_wake,
    input wire logic        o_s_axi_awready,
    input wire logic        o_s_axi_bvalid,
    input wire logic        i_s_axi_bready,
    input wire logic        o_s_axi_rvalid,
    input wire logic        i_s_axi_rready,
    input wire logic [31:0] o_s_axi_rdata
);
    logic [16:0] upto;
    // nesting bits at the offered level or above it in priority
    assign upto = (17'h00001 << (o_evt_level + 1)) - 17'h00001;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_bvalid_hold: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
        else $error("write response dropped before bready");
    a_rdata_hold: assert property (o_s_axi_rvalid && !i_s_axi_rready
        |=> o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read data not held");
    a_aw_blocked: assert property (o_s_axi_bvalid |-> !o_s_axi_awready)
        else $error("awready high during response");
    a_level_range: assert property (o_evt_req |-> o_evt_level >= 4'h7)
        else $error("offered level outside general range");
    a_priority_gate: assert property (o_evt_req |-> (o_core_event_nesting & upto[15:0]) == 16'h0000)
        else $error("event offered under equal or higher nesting");
    a_nest_accept: assert property (o_evt_req && i_evt_accept
        |=> o_core_event_nesting[$past(o_evt_level)]) else $error("accept did not set nesting");
    a_nest_cause: assert property (!$stable(o_core_event_nesting)
        |-> $past(i_evt_accept) || $past(|i_evt_return)) else $error("nesting changed alone");
    a_off_blocks: assert property (i_global_irq_disable_instr |=> !o_evt_req[*2])
        else $error("event offered after global disable");
    a_wake_idle: assert property (o_wake |-> $past(i_core_idle))
        else $error("wake while core busy");
    c_accept: cover property (o_evt_req && i_evt_accept);
    c_wake: cover property (o_wake);
    c_write: cover property (o_s_axi_bvalid && i_s_axi_bready);
endmodule
bind two_stage_event_controller event_ctrl_chk i_event_ctrl_chk (.*);

// >>> testbench/core_pipe_model.sv
/* core pipeline model: takes offered events after a delay, returns later.
   assumes one event in flight and that an offer stands until taken. */
`timescale 1ns/1ps
module core_pipe_model (
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_evt_req,
    input  wire logic [3:0]  i_evt_level,
    input  wire logic [3:0]  i_delay,
    input  wire logic [7:0]  i_hold,
    output logic             o_evt_accept,
    output logic [15:0]      o_evt_return
);
    logic [3:0] wait_ff, lvl_ff;
    logic [7:0] hold_ff;
    logic       busy_ff;
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_evt_accept <= 1'b0;
            o_evt_return <= 16'h0000;
            wait_ff      <= 4'h0;
            lvl_ff       <= 4'h0;
            hold_ff      <= 8'h00;
            busy_ff      <= 1'b0;
        end else begin
            o_evt_accept <= 1'b0;
            o_evt_return <= 16'h0000;
            if (busy_ff) begin
                hold_ff <= hold_ff - 8'h01;
                if (hold_ff == 8'h00) begin
                    o_evt_return <= 16'h0001 << lvl_ff;
                    busy_ff      <= 1'b0;
                end
            end else if (o_evt_accept) begin
                busy_ff <= 1'b1;
                hold_ff <= i_hold;
                lvl_ff  <= i_evt_level;
            end else if (i_evt_req) begin
                wait_ff <= wait_ff + 4'h1;
                if (wait_ff >= i_delay) begin
                    o_evt_accept <= 1'b1;
                    wait_ff      <= 4'h0;
                end
            end
        end
    end
endmodule

// >>> testbench/testbench.sv
/* testbench for the two-stage event controller over axi4-lite.
   assumes the core pipeline model answers offered events. */
`timescale 1ns/1ps
module testbench;
    logic        i_ref_clk, i_sys_rst, i_supervisor, i_global_irq_enable_instr;
    logic        i_global_irq_disable_instr, i_core_idle, i_evt_accept, o_evt_req, o_wake;
    logic [55:0] i_periph_irq;
    logic [15:0] i_evt_return, o_core_event_nesting;
    logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
    logic        o_s_axi_rvalid, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
    logic        i_s_axi_arvalid, i_s_axi_rready;
    logic [3:0]  o_evt_level, i_s_axi_wstrb, delay;
    logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr, hold;
    logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rv;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
    int          n_errors, checks_done;
    two_stage_event_controller i_two_stage_event_controller (.*);
    core_pipe_model i_core_pipe_model (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_evt_req(o_evt_req), .i_evt_level(o_evt_level), .i_delay(delay), .i_hold(hold),
        .o_evt_accept(i_evt_accept), .o_evt_return(i_evt_return));
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    task summarize();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge i_ref_clk);
        i_s_axi_awaddr  <= a;
        i_s_axi_wdata   <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid  <= 1'b1;
        i_s_axi_bready  <= 1'b1;
        forever begin
            @(posedge i_ref_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
            if (o_s_axi_bvalid) break;
        end
        i_s_axi_bready <= 1'b0;
        chk({30'h0, o_s_axi_bresp}, {30'h0, r});
    endtask
    task rd(input logic [7:0] a, input logic [1:0] r);
        @(posedge i_ref_clk);
        i_s_axi_araddr  <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready  <= 1'b1;
        forever begin
            @(posedge i_ref_clk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
            if (o_s_axi_rvalid) break;
        end
        i_s_axi_rready <= 1'b0;
        rv = o_s_axi_rdata;
        chk({30'h0, o_s_axi_rresp}, {30'h0, r});
    endtask
    task line(input int k, input logic v);
        @(posedge i_ref_clk);
        i_periph_irq[k] <= v;
    endtask
    task wait_nest(input int b);
        for (int i = 0; i < 300 && o_core_event_nesting[b] !== 1'b1; i++) @(posedge i_ref_clk);
    endtask
    task t_regs();
        rd(event_ctrl_pkg::OFS_LATCH, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0000);
        rd(event_ctrl_pkg::OFS_PWAKE1, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0000);
        rd(event_ctrl_pkg::OFS_ASSIGN0 + 8'h10, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h5555_5555);
        rd(event_ctrl_pkg::OFS_ASSIGN0 + 8'h14, event_ctrl_pkg::RESP_OKAY);
        chk(rv[19:16], 4'h6);
        rd(event_ctrl_pkg::OFS_ASSIGN0 + 8'h18, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h3333_3003);
        rd(event_ctrl_pkg::OFS_GLOBAL, event_ctrl_pkg::RESP_OKAY);
        chk(rv[0], 1'b1);
        rd(8'h4C, event_ctrl_pkg::RESP_SLVERR);
        wr(event_ctrl_pkg::OFS_UNMASK, 32'hFFFF_FFFF, event_ctrl_pkg::RESP_OKAY);
        rd(event_ctrl_pkg::OFS_UNMASK, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_FFFF);
        wr(event_ctrl_pkg::OFS_UNMASK, 32'h0000_0000, event_ctrl_pkg::RESP_OKAY);
    endtask
    task t_super();
        i_supervisor <= 1'b0;
        wr(event_ctrl_pkg::OFS_UNMASK, 32'h0000_1000, event_ctrl_pkg::RESP_SLVERR);
        rd(event_ctrl_pkg::OFS_NESTING, event_ctrl_pkg::RESP_SLVERR);
        i_supervisor <= 1'b1;
        rd(event_ctrl_pkg::OFS_UNMASK, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0000);
    endtask
    task t_sysmask();
        wr(event_ctrl_pkg::OFS_UNMASK, 32'h0000_1000, event_ctrl_pkg::RESP_OKAY);
        line(32, 1'b1);
        repeat (8) @(posedge i_ref_clk);
        rd(event_ctrl_pkg::OFS_LATCH, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0000);
        rd(event_ctrl_pkg::OFS_PSTATE1, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0001);
        line(32, 1'b0);
        repeat (4) @(posedge i_ref_clk);
        rd(event_ctrl_pkg::OFS_PSTATE1, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0000);
    endtask
    task t_flow();
        int n;
        wr(event_ctrl_pkg::OFS_PUNMASK1, 32'h0000_0001, event_ctrl_pkg::RESP_OKAY);
        line(32, 1'b1);
        for (n = 0; n < 300 && o_core_event_nesting[12] !== 1'b1; n++) @(posedge i_ref_clk);
        chk(n >= 3 && n < 300, 1'b1);
        rd(event_ctrl_pkg::OFS_LATCH, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0000);
        line(32, 1'b0);
        repeat (3) @(posedge i_ref_clk);
        line(32, 1'b1);
        repeat (6) @(posedge i_ref_clk);
        rd(event_ctrl_pkg::OFS_LATCH, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_1000);
        chk(o_core_event_nesting, 16'h1000);
        repeat (400) @(posedge i_ref_clk);
        rd(event_ctrl_pkg::OFS_LATCH, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0000);
        chk(o_core_event_nesting, 16'h0000);
        line(32, 1'b0);
    endtask
    task t_mask();
        wr(event_ctrl_pkg::OFS_UNMASK, 32'h0000_0000, event_ctrl_pkg::RESP_OKAY);
        line(32, 1'b1);
        repeat (6) @(posedge i_ref_clk);
        chk(o_evt_req, 1'b0);
        rd(event_ctrl_pkg::OFS_LATCH, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_1000);
        wr(event_ctrl_pkg::OFS_LATCH, 32'h0000_0000, event_ctrl_pkg::RESP_OKAY);
        rd(event_ctrl_pkg::OFS_LATCH, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_0000);
        wr(event_ctrl_pkg::OFS_LATCH, 32'h0000_1000, event_ctrl_pkg::RESP_OKAY);
        i_global_irq_disable_instr <= 1'b1;
        @(posedge i_ref_clk);
        i_global_irq_disable_instr <= 1'b0;
        wr(event_ctrl_pkg::OFS_UNMASK, 32'h0000_1000, event_ctrl_pkg::RESP_OKAY);
        wr(event_ctrl_pkg::OFS_LATCH, 32'h0000_0000, event_ctrl_pkg::RESP_OKAY);
        rd(event_ctrl_pkg::OFS_LATCH, event_ctrl_pkg::RESP_OKAY);
        chk(rv, 32'h0000_1000);
        chk(o_evt_req, 1'b0);
        i_global_irq_enable_instr <= 1'b1;
        @(posedge i_ref_clk);
        i_global_irq_enable_instr <= 1'b0;
        wait_nest(12);
        chk(o_core_event_nesting[12], 1'b1);
        line(32, 1'b0);
        repeat (150) @(posedge i_ref_clk);
    endtask
    task t_route_wake();
        delay <= 4'h8;
        wr(event_ctrl_pkg::OFS_ASSIGN0 + 8'h10, 32'h5555_5550, event_ctrl_pkg::RESP_OKAY);
        wr(event_ctrl_pkg::OFS_UNMASK, 32'h0000_0080, event_ctrl_pkg::RESP_OKAY);
        wr(event_ctrl_pkg::OFS_PWAKE1, 32'h0000_0001, event_ctrl_pkg::RESP_OKAY);
        i_core_idle <= 1'b1;
        line(32, 1'b1);
        wait_nest(7);
        chk(o_core_event_nesting, 16'h0080);
        chk(o_wake, 1'b1);
        i_core_idle <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        chk(o_wake, 1'b0);
        line(32, 1'b0);
    endtask
    initial begin
        {i_supervisor, i_s_axi_wstrb, hold} = {1'b1, 4'hF, 8'h64};
        {i_global_irq_enable_instr, i_global_irq_disable_instr, i_core_idle} = 3'b000;
        {i_periph_irq, delay, i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid} = 4'h0;
        {i_s_axi_rready, n_errors, checks_done} = '0;
        i_sys_rst = 1'b1;
        repeat (10) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        t_regs();
        t_super();
        t_sysmask();
        t_flow();
        t_mask();
        t_route_wake();
        summarize();
    end
    // whole run stays under 1000 cycles; 20000 cycles means a hang
    initial begin
        #400000;
        n_errors++;
        summarize();
    end
endmodule
